// ==== logic/irq_consts.svh ====
// constants of the nested interrupt controller
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CC 10'h020
`define IDX_PRIO0 10'h024
`define IDX_PRIO1 10'h025
`define IDX_PRIO2 10'h026
`define IDX_PRIO3 10'h027

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define CC_RESET 8'hEA
`define PRIO_RESET 8'hFF
`define PRIO3_RO_ONES 8'hF0
`define CC_HIGH_BIT 5
`define CC_LOW_BIT 3

// ----------------------------------------
// level pair codes {high, low}
// ----------------------------------------
`define PAIR_MAIN 2'h2
`define PAIR_LVL1 2'h1
`define PAIR_LVL2 2'h0
`define PAIR_MASKED 2'h3

// ----------------------------------------
// vectors
// ----------------------------------------
`define VEC_RESET_ADDR 16'hFFFE
`define VEC_TRAP_ADDR 16'hFFFC
`define VEC_BASE_ADDR 16'hFFFA
`define VEC_LAST 4'hD
`define VEC_SERIAL 4'h7
`define VEC_PWM_TIMER 4'hD
`define MASKABLE_VECS 14'h3FBE
`define HALT_WAKE_VECS 14'h003F

`endif

// ==== logic/irq_pkg.sv ====
// types of the nested interrupt controller
package irq_pkg;

   // ----------------------------------------
   // dedicated instructions reported by the core
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_NONE,
      OP_ENABLE,
      OP_DISABLE,
      OP_HALT,
      OP_WAIT,
      OP_TRAP,
      OP_RETURN,
      OP_POP_CONDITION_CODE
   } cpu_op_e;

   typedef enum logic [1:0] {
      SVC_RESET,
      SVC_TRAP,
      SVC_IRQ
   } svc_kind_e;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      cpu_op_e op;
      logic [7:0] stack_cc;
   } cpu_op_s;

   typedef struct packed {
      logic take;
      svc_kind_e kind;
      logic [3:0] num;
      logic [15:0] addr;
   } svc_s;

endpackage : irq_pkg

// ==== logic/nested_irq_ctrl.sv ====
// nested vectored interrupt controller with apb priority registers
`timescale 1ns/100ps
`include "irq_consts.svh"

module nested_irq_ctrl (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // interrupt sources
   input wire logic [13:0] IRQ_REQ_I,
   input wire logic TLI_PIN_I,
   input wire logic TLI_ENABLE_I,
   input wire logic SERIAL_SLAVE_I,
   input wire logic PWM_EXT_CLK_I,
   // cpu core
   input wire logic INSTR_END_I,
   input wire irq_pkg::cpu_op_s CPU_OP_I,
   input wire logic FLAGS_WE_I,
   input wire logic [7:0] FLAGS_I,
   output irq_pkg::svc_s SERVICE_O,
   output logic [7:0] CC_O,
   output logic JUMP_MASKED_O,
   output logic JUMP_UNMASKED_O,
   output logic CPU_STOPPED_O,
   output logic WAKE_O
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [1:0] lvl_num(input logic [1:0] pair);
      case (pair)
         `PAIR_MAIN: lvl_num = 2'h0;
         `PAIR_LVL1: lvl_num = 2'h1;
         `PAIR_LVL2: lvl_num = 2'h2;
         default: lvl_num = 2'h3;
      endcase
   endfunction : lvl_num

   function automatic logic [15:0] vec_addr(input logic [3:0] num);
      vec_addr = `VEC_BASE_ADDR - {11'h000, num, 1'b0};
   endfunction : vec_addr

   localparam logic [13:0] maskable_vecs = `MASKABLE_VECS;

   logic [7:0] cc_r, cc_nxt, mem_rd;
   logic masked_r, unmasked_r, rst_pend_r;
   logic halted_r, waiting_r, halt_first_r, wake_r, stopped_r;
   logic tli_s1_r, tli_s2_r, tli_s3_r, tli_pend_r;
   irq_pkg::svc_s svc_r;
   logic [31:0] prdata_r, levels;
   logic pready_r, pslverr_r;
   logic [13:0] wake_cap, cand;
   logic [1:0] cur_lvl, best_lvl, win_pair;
   logic [3:0] best_num;
   logic best_hit, op_valid, take_tli, take_irq, take_trap, halt_wake, wait_wake;
   logic [9:0] apb_idx;
   logic is_cc, is_prio, apb_done;

   // ----------------------------------------
   // priority storage
   // ----------------------------------------
   assign apb_idx = PADDR_I[11:2];
   assign is_cc = (apb_idx == `IDX_CC);
   assign is_prio = (apb_idx >= `IDX_PRIO0) && (apb_idx <= `IDX_PRIO3);
   assign apb_done = PSEL_I && PENABLE_I && pready_r;

   prio_regs u_prio (
      .clk_i(MCLK_I),
      .rst_b_i(RST_B_I),
      .wr_en_i(apb_done && PWRITE_I && is_prio),
      .wr_idx_i(apb_idx[1:0]),
      .wr_data_i(PWDATA_I[7:0]),
      .rd_idx_i(apb_idx[1:0]),
      .rd_data_o(mem_rd),
      .levels_o(levels)
   );

   // ----------------------------------------
   // apb slave: one wait state, read data and error registered
   // ----------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= PSEL_I && PENABLE_I && !pready_r;
         if (PSEL_I && PENABLE_I && !pready_r) begin
            pslverr_r <= !(is_cc || is_prio);
            if (is_cc) begin
               prdata_r <= {24'h00_0000, cc_r};
            end else if (is_prio) begin
               prdata_r <= {24'h00_0000, mem_rd};
            end else begin
               prdata_r <= 32'h0000_0000;
            end
         end else if (!PSEL_I) begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // top-level pin: synchronise, rising edge latched
   // ----------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tli_s1_r <= 1'b0;
         tli_s2_r <= 1'b0;
         tli_s3_r <= 1'b0;
      end else begin
         tli_s1_r <= TLI_PIN_I;
         tli_s2_r <= tli_s1_r;
         tli_s3_r <= tli_s2_r;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tli_pend_r <= 1'b0;
      end else if (TLI_ENABLE_I && tli_s2_r && !tli_s3_r) begin
         tli_pend_r <= 1'b1;
      end else if (take_tli) begin
         tli_pend_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // arbitration
   // ----------------------------------------
   assign cur_lvl = lvl_num({cc_r[`CC_HIGH_BIT], cc_r[`CC_LOW_BIT]});
   assign wake_cap = `HALT_WAKE_VECS
      | ({13'h0000, SERIAL_SLAVE_I} << `VEC_SERIAL)
      | ({13'h0000, PWM_EXT_CLK_I} << `VEC_PWM_TIMER);

   genvar v;
   generate
      for (v = 0; v < 14; v++) begin : g_cand
         // pair of vector v at register v/4, bits 2*(v mod 4)
         assign cand[v] = IRQ_REQ_I[v] && maskable_vecs[v]
            && (lvl_num(levels[2*v +: 2]) > cur_lvl)
            && (!halt_first_r || wake_cap[v]);
      end
   endgenerate

   always_comb begin
      best_hit = 1'b0;
      best_lvl = 2'h0;
      best_num = 4'h0;
      win_pair = `PAIR_MASKED;
      for (int i = 13; i >= 1; i--) begin
         if (cand[i] && (!best_hit || lvl_num(levels[2*i +: 2]) >= best_lvl)) begin
            best_hit = 1'b1;
            best_lvl = lvl_num(levels[2*i +: 2]);
            best_num = 4'(i);
            win_pair = levels[2*i +: 2];
         end
      end
   end

   assign op_valid = CPU_OP_I.op != irq_pkg::OP_NONE;
   assign take_trap = !rst_pend_r && CPU_OP_I.op == irq_pkg::OP_TRAP;
   assign take_tli = !rst_pend_r && INSTR_END_I && !op_valid && !CPU_STOPPED_O
      && tli_pend_r;
   assign take_irq = !rst_pend_r && INSTR_END_I && !op_valid && !CPU_STOPPED_O
      && !tli_pend_r && best_hit;

   // ----------------------------------------
   // condition code
   // ----------------------------------------
   always_comb begin
      cc_nxt = cc_r;
      if (FLAGS_WE_I) begin
         cc_nxt[4] = FLAGS_I[4];
         cc_nxt[2:0] = FLAGS_I[2:0];
      end
      if (take_trap || take_tli) begin
         {cc_nxt[`CC_HIGH_BIT], cc_nxt[`CC_LOW_BIT]} = `PAIR_MASKED;
      end else if (take_irq) begin
         {cc_nxt[`CC_HIGH_BIT], cc_nxt[`CC_LOW_BIT]} = win_pair;
      end else begin
         case (CPU_OP_I.op)
            irq_pkg::OP_ENABLE, irq_pkg::OP_HALT, irq_pkg::OP_WAIT: begin
               {cc_nxt[`CC_HIGH_BIT], cc_nxt[`CC_LOW_BIT]} = `PAIR_MAIN;
            end
            irq_pkg::OP_DISABLE: begin
               {cc_nxt[`CC_HIGH_BIT], cc_nxt[`CC_LOW_BIT]} = `PAIR_MASKED;
            end
            irq_pkg::OP_RETURN, irq_pkg::OP_POP_CONDITION_CODE: begin
               cc_nxt = CPU_OP_I.stack_cc | 8'hC0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         cc_r <= `CC_RESET;
         masked_r <= 1'b1;
         unmasked_r <= 1'b0;
      end else begin
         cc_r <= cc_nxt;
         masked_r <= cc_nxt[`CC_HIGH_BIT] && cc_nxt[`CC_LOW_BIT];
         unmasked_r <= !(cc_nxt[`CC_HIGH_BIT] && cc_nxt[`CC_LOW_BIT]);
      end
   end

   // ----------------------------------------
   // low power states and wake-up
   // ----------------------------------------
   assign halt_wake = tli_pend_r || |(IRQ_REQ_I & `MASKABLE_VECS & wake_cap);
   assign wait_wake = tli_pend_r || |(IRQ_REQ_I & `MASKABLE_VECS);

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         halted_r <= 1'b0;
         waiting_r <= 1'b0;
         wake_r <= 1'b0;
         stopped_r <= 1'b0;
      end else begin
         wake_r <= (halted_r && halt_wake) || (waiting_r && wait_wake);
         stopped_r <= (halted_r ? !halt_wake : CPU_OP_I.op == irq_pkg::OP_HALT)
            || (waiting_r ? !wait_wake : CPU_OP_I.op == irq_pkg::OP_WAIT);
         if (halted_r && halt_wake) begin
            halted_r <= 1'b0;
         end else if (CPU_OP_I.op == irq_pkg::OP_HALT) begin
            halted_r <= 1'b1;
         end
         if (waiting_r && wait_wake) begin
            waiting_r <= 1'b0;
         end else if (CPU_OP_I.op == irq_pkg::OP_WAIT) begin
            waiting_r <= 1'b1;
         end
      end
   end

   // first service after halt is restricted to halt-capable vectors
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         halt_first_r <= 1'b0;
      end else if (halted_r && halt_wake) begin
         halt_first_r <= 1'b1;
      end else if (take_irq || take_tli || take_trap) begin
         halt_first_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // service request to the core
   // ----------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_pend_r <= 1'b1;
         svc_r <= '0;
      end else begin
         rst_pend_r <= 1'b0;
         svc_r.take <= rst_pend_r || take_trap || take_tli || take_irq;
         if (rst_pend_r) begin
            svc_r.kind <= irq_pkg::SVC_RESET;
            svc_r.num <= 4'h0;
            svc_r.addr <= `VEC_RESET_ADDR;
         end else if (take_trap) begin
            svc_r.kind <= irq_pkg::SVC_TRAP;
            svc_r.num <= 4'h0;
            svc_r.addr <= `VEC_TRAP_ADDR;
         end else if (take_tli) begin
            svc_r.kind <= irq_pkg::SVC_IRQ;
            svc_r.num <= 4'h0;
            svc_r.addr <= `VEC_BASE_ADDR;
         end else if (take_irq) begin
            svc_r.kind <= irq_pkg::SVC_IRQ;
            svc_r.num <= best_num;
            svc_r.addr <= vec_addr(best_num);
         end
      end
   end

   assign SERVICE_O = svc_r;
   assign CC_O = cc_r;
   assign JUMP_MASKED_O = masked_r;
   assign JUMP_UNMASKED_O = unmasked_r;
   assign CPU_STOPPED_O = stopped_r;
   assign WAKE_O = wake_r;
   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_B_I);

   halt_wake_a: assert property (halted_r && halt_wake |=> WAKE_O && !halted_r)
      else $error("halt not left on capable request");
   wait_wake_a: assert property (waiting_r && wait_wake |=> WAKE_O && !waiting_r)
      else $error("wait not left on request");
   first_cap_a: assert property (halt_first_r && take_irq |-> wake_cap[best_num])
      else $error("first service after halt not halt-capable");
   level_load_a: assert property (take_irq |=> {cc_r[5], cc_r[3]} == $past(win_pair))
      else $error("entry level not loaded from priority pair");
   level_gate_a: assert property (take_irq |-> best_lvl > cur_lvl)
      else $error("request served at or below current level");
   enable_op_a: assert property (CPU_OP_I.op == irq_pkg::OP_ENABLE && !take_trap
      && !take_tli && !take_irq |=> {cc_r[5], cc_r[3]} == `PAIR_MAIN)
      else $error("enable did not load main level");
   jump_cond_a: assert property (JUMP_MASKED_O == (cc_r[5] && cc_r[3])
      && JUMP_UNMASKED_O != JUMP_MASKED_O)
      else $error("jump conditions disagree with level");
   trap_take_a: assert property (take_trap |=> SERVICE_O.take
      && SERVICE_O.kind == irq_pkg::SVC_TRAP && SERVICE_O.addr == `VEC_TRAP_ADDR
      ##1 (!SERVICE_O.take || $past(take_tli || take_irq || take_trap)))
      else $error("trap not serviced");
   tli_level_a: assert property (take_tli |=> cc_r[5] && cc_r[3])
      else $error("pin vector did not set level 3");
   vec_addr_a: assert property (SERVICE_O.take && SERVICE_O.kind == irq_pkg::SVC_IRQ
      |-> SERVICE_O.addr == 16'hFFFA - {11'h000, SERVICE_O.num, 1'b0})
      else $error("vector address wrong");
   apb_ready_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
      else $error("apb access not answered in one wait state");

   halt_exit_c: cover property (halted_r ##1 WAKE_O ##[1:16] SERVICE_O.take);
   trap_c: cover property (take_trap);
   nest_c: cover property (take_irq && cur_lvl != 2'h0);
   tli_c: cover property (take_tli);

endmodule : nested_irq_ctrl

// ==== logic/prio_regs.sv ====
// storage of the four vector priority registers
`timescale 1ns/100ps
`include "irq_consts.svh"

module prio_regs (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic wr_en_i,
   input wire logic [1:0] wr_idx_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [1:0] rd_idx_i,
   output logic [7:0] rd_data_o,
   output logic [31:0] levels_o
);

   logic [7:0] regs_r [4];

   // ----------------------------------------
   // pair filter: level-0 code keeps the old pair
   // ----------------------------------------
   function automatic logic [7:0] filter(input logic [7:0] old_v, input logic [7:0] new_v);
      logic [7:0] res;
      res = new_v;
      for (int p = 0; p < 4; p++) begin
         if (new_v[2*p +: 2] == `PAIR_MAIN) begin
            res[2*p +: 2] = old_v[2*p +: 2];
         end
      end
      return res;
   endfunction : filter

   genvar r;
   generate
      for (r = 0; r < 4; r++) begin : g_reg
         localparam logic [7:0] RO_MASK = (r == 3) ? `PRIO3_RO_ONES : 8'h00;
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               regs_r[r] <= `PRIO_RESET;
            end else if (wr_en_i && wr_idx_i == 2'(r)) begin
               regs_r[r] <= filter(regs_r[r], wr_data_i) | RO_MASK;
            end
         end
         assign levels_o[8*r +: 8] = regs_r[r];
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= regs_r[rd_idx_i];
      end
   end

endmodule : prio_regs

// ==== verification/cpu_core_model.sv ====
// core-side model: instruction boundaries, dedicated ops, context stack
`timescale 1ns/100ps

module cpu_core_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // bench commands
   input wire logic step_i,
   input wire logic op_go_i,
   input wire irq_pkg::cpu_op_e op_i,
   // controller side
   input wire irq_pkg::svc_s svc_i,
   input wire logic [7:0] cc_i,
   input wire logic stopped_i,
   output logic instr_end_o,
   output irq_pkg::cpu_op_s cpu_op_o
);
   logic [7:0] stk_r [0:15];
   logic [3:0] sp_r;
   logic [7:0] held_r;

   // a stopped core reaches no boundary
   assign instr_end_o = step_i && !stopped_i;

   always_comb begin
      cpu_op_o.op = op_go_i ? op_i : irq_pkg::OP_NONE;
      cpu_op_o.stack_cc = stk_r[sp_r - 4'h1];
   end

   // ----
   // context taken in the request cycle, so it holds the old level
   // ----
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sp_r <= 4'h0;
         held_r <= 8'h00;
      end else begin
         if (instr_end_o || cpu_op_o.op == irq_pkg::OP_TRAP) begin
            held_r <= cc_i;
         end
         if (svc_i.take && svc_i.kind != irq_pkg::SVC_RESET) begin
            stk_r[sp_r] <= held_r;
            sp_r <= sp_r + 4'h1;
         end else if (cpu_op_o.op == irq_pkg::OP_RETURN) begin
            sp_r <= sp_r - 4'h1;
         end
      end
   end
endmodule : cpu_core_model

// ==== verification/nested_priority_interrupt_ctrl_tb.sv ====
// self-checking bench of the nested interrupt controller
`timescale 1ns/100ps

module nested_priority_interrupt_ctrl_tb;
   localparam irq_pkg::cpu_op_e step_op = irq_pkg::OP_NONE;
   localparam irq_pkg::cpu_op_e ret_op = irq_pkg::OP_RETURN;
   typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_s;
   row_s rows [7] = '{'{12'h090, 8'hCF, 8'hCF}, '{12'h090, 8'h64, 8'h44},
      '{12'h09C, 8'h00, 8'hF0}, '{12'h09C, 8'h0A, 8'hF0}, '{12'h094, 8'hAA, 8'hFF},
      '{12'h098, 8'h00, 8'h00}, '{12'h080, 8'h00, 8'hEA}};
   logic [1:0] rp [3] = '{2'h0, 2'h1, 2'h2};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic [13:0] irq = 14'h0;
   logic pin = 1'b0, pwm_ext = 1'b0, step = 1'b0, op_go = 1'b0, ser_slave = 1'b0;
   irq_pkg::cpu_op_e op = irq_pkg::OP_NONE;
   irq_pkg::cpu_op_s cpu_op;
   irq_pkg::svc_s svc;
   logic instr_end, jm, jn, stopped, wake;
   logic [7:0] cc;
   int bad_count = 0, tests_run = 0;

   always #12.5 clk = ~clk;

   nested_irq_ctrl uut (.MCLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_REQ_I(irq), .TLI_PIN_I(pin),
      .TLI_ENABLE_I(1'b1), .SERIAL_SLAVE_I(ser_slave), .PWM_EXT_CLK_I(pwm_ext),
      .INSTR_END_I(instr_end), .CPU_OP_I(cpu_op), .FLAGS_WE_I(1'b0), .FLAGS_I(8'h00),
      .SERVICE_O(svc), .CC_O(cc), .JUMP_MASKED_O(jm), .JUMP_UNMASKED_O(jn),
      .CPU_STOPPED_O(stopped), .WAKE_O(wake));

   cpu_core_model core (.clk_i(clk), .rst_b_i(rst_b), .step_i(step), .op_go_i(op_go),
      .op_i(op), .svc_i(svc), .cc_i(cc), .stopped_i(stopped), .instr_end_o(instr_end),
      .cpu_op_o(cpu_op));

   // ----
   // shared tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      check(n < 16, 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   // one boundary or op, then the taken vector and the level it leaves
   task automatic svc_t(input irq_pkg::cpu_op_e o, input logic tk, input logic [15:0] ad,
                        input logic [1:0] pr);
      logic seen;
      logic [15:0] sa;
      logic [3:0] sn;
      seen = 1'b0;
      sa = 16'h0;
      sn = 4'h0;
      @(posedge clk);
      op <= o;
      op_go <= (o != step_op);
      step <= (o == step_op);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         op_go <= 1'b0;
         step <= 1'b0;
         #1;
         if (svc.take === 1'b1) begin
            seen = 1'b1;
            sa = svc.addr;
            sn = svc.num;
         end
      end
      check(seen, tk);
      if (tk) check(sa, ad);
      if (tk && ad <= 16'hFFFA) check(sn, (16'hFFFA - ad) >> 1);
      check({cc[5], cc[3]}, pr);
      check(jm, pr == 2'h3);
      check(jn, pr != 2'h3);
      @(posedge clk);
   endtask : svc_t

   task automatic wait_wake(input logic exp);
      logic w;
      w = 1'b0;
      repeat (8) begin
         @(posedge clk);
         #1;
         if (wake === 1'b1) w = 1'b1;
      end
      check(w, exp);
      check(stopped, !exp);
      @(posedge clk);
   endtask : wait_wake

   task automatic reset_done();
      @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      check(svc.take, 1'b1);
      check(svc.kind, irq_pkg::SVC_RESET);
      check(svc.addr, 16'hFFFE);
      @(posedge clk);
   endtask : reset_done

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run

   initial begin
      #100000;
      bad_count++;
      complete_run();
   end

   initial begin
      repeat (16) @(posedge clk);
      check(cc, 8'hEA);
      check(jm, 1'b1);
      reset_done();
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'h090 + 12'(4 * i), 8'h00);
         check(rd, 32'hFF);
      end
      apb(1'b0, 12'h0C0, 8'h00);
      check(err, 1'b1);
      check(rd, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 8'h00);
         check(rd, {24'h0, rows[i].e});
         check(err, 1'b0);
      end
      $display("test registers done");
      svc_t(irq_pkg::OP_ENABLE, 1'b0, 16'h0, 2'h2);
      @(posedge clk);
      irq <= 14'h010C;
      svc_t(step_op, 1'b1, 16'hFFF6, 2'h0);
      irq <= 14'h0108;
      svc_t(step_op, 1'b0, 16'h0, 2'h0);
      svc_t(ret_op, 1'b0, 16'h0, 2'h2);
      svc_t(step_op, 1'b1, 16'hFFEA, 2'h0);
      irq <= 14'h0008;
      svc_t(ret_op, 1'b0, 16'h0, 2'h2);
      svc_t(step_op, 1'b1, 16'hFFF4, 2'h1);
      irq <= 14'h0208;
      svc_t(step_op, 1'b1, 16'hFFE8, 2'h0);
      apb(1'b1, 12'h098, 8'h0C);
      svc_t(step_op, 1'b1, 16'hFFE8, 2'h3);
      irq <= 14'h0000;
      foreach (rp[i]) svc_t(ret_op, 1'b0, 16'h0, rp[i]);
      $display("test nesting done");
      @(posedge clk);
      irq <= 14'h0004;
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      svc_t(step_op, 1'b1, 16'hFFFA, 2'h3);
      svc_t(ret_op, 1'b0, 16'h0, 2'h2);
      svc_t(step_op, 1'b1, 16'hFFF6, 2'h0);
      irq <= 14'h0000;
      svc_t(ret_op, 1'b0, 16'h0, 2'h2);
      svc_t(irq_pkg::OP_DISABLE, 1'b0, 16'h0, 2'h3);
      svc_t(irq_pkg::OP_TRAP, 1'b1, 16'hFFFC, 2'h3);
      svc_t(ret_op, 1'b0, 16'h0, 2'h3);
      svc_t(irq_pkg::OP_ENABLE, 1'b0, 16'h0, 2'h2);
      $display("test pin and trap done");
      svc_t(irq_pkg::OP_HALT, 1'b0, 16'h0, 2'h2);
      irq <= 14'h2100;
      wait_wake(1'b0);
      pwm_ext <= 1'b1;
      wait_wake(1'b1);
      svc_t(step_op, 1'b1, 16'hFFE0, 2'h0);
      irq <= 14'h0100;
      svc_t(ret_op, 1'b0, 16'h0, 2'h2);
      svc_t(step_op, 1'b1, 16'hFFEA, 2'h0);
      irq <= 14'h0000;
      svc_t(irq_pkg::OP_WAIT, 1'b0, 16'h0, 2'h2);
      irq <= 14'h0400;
      wait_wake(1'b1);
      svc_t(step_op, 1'b1, 16'hFFE6, 2'h0);
      irq <= 14'h0000;
      svc_t(irq_pkg::OP_POP_CONDITION_CODE, 1'b0, 16'h0, 2'h2);
      svc_t(irq_pkg::OP_HALT, 1'b0, 16'h0, 2'h2);
      irq <= 14'h0080;
      wait_wake(1'b0);
      ser_slave <= 1'b1;
      wait_wake(1'b1);
      svc_t(step_op, 1'b1, 16'hFFEC, 2'h3);
      irq <= 14'h0000;
      svc_t(ret_op, 1'b0, 16'h0, 2'h2);
      $display("test low power done");
      @(posedge clk);
      rst_b <= 1'b0;
      #5;
      check(cc, 8'hEA);
      reset_done();
      apb(1'b0, 12'h090, 8'h00);
      check(rd, 32'hFF);
      $display("test second reset done");
      complete_run();
   end
endmodule : nested_priority_interrupt_ctrl_tb
